// ==== dmc_pkg.sv ====
/*
 debug memory-access command interpreter package: opcodes, frame states, memory request carriers.
 assumes one system clock and a byte stream already deserialised from the debug serial line.
*/
package dmc_pkg;
  localparam logic [7:0] OP_WR_PROG = 8'h0A;
  localparam logic [7:0] OP_RD_PROG = 8'h0B;
  localparam logic [7:0] OP_WR_DATA = 8'h0C;
  localparam logic [7:0] OP_RD_DATA = 8'h0D;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam int         ADDR_W     = 16;
  localparam int         CNT_W      = 17;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_CNT_HI, ST_CNT_LO, ST_WRITE, ST_READ, ST_READ_WAIT
  } dmc_state_e;

  typedef struct packed {
    logic                  valid;
    logic                  wr;
    logic                  prog;
    logic [ADDR_W-1:0]     addr;
    logic [7:0]            wdata;
  } dmc_mem_req_s;
endpackage

// ==== dmc_mem_cmd.sv ====
/*
 debug memory-access command interpreter: parses opcode, address, count frames from the
 debug serial line byte stream and issues program/data memory accesses.
 assumes memory answers a read with rd_valid a fixed or variable number of cycles later,
 and the byte transmitter accepts a byte when tx_ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a program memory write frame is taken whole but its data is dropped outside debug mode or under read protection.
// - a program memory read takes opcode 0BH, address and count high then low, and returns count bytes.
// - the byte count selects 1 to 65536 bytes, a count of 0 meaning 65536.
// - a program memory read outside debug mode or under read protection returns FFH for each byte.
// - a data memory write takes opcode 0CH, address, count and data, dropping data outside debug mode or under protection.
// - a data memory read takes opcode 0DH, address and count, returning FFH only outside debug mode.
module dmc_mem_cmd (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    debug_mode,
  input  wire logic                    read_protect,
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_data,
  input  wire logic                    tx_ready,
  output logic                         tx_valid,
  output logic [7:0]                   tx_data,
  output dmc_pkg::dmc_mem_req_s        mem_req,
  input  wire logic                    mem_rd_valid,
  input  wire logic [7:0]              mem_rd_data,
  output logic                         busy
);
  dmc_pkg::dmc_state_e             state_q;
  logic [7:0]                      op_q;
  logic [dmc_pkg::ADDR_W-1:0]      addr_q;
  logic [dmc_pkg::CNT_W-1:0]       left_q;
  logic                            blank_q;

  function automatic logic is_known(input logic [7:0] op);
    is_known = (op == dmc_pkg::OP_WR_PROG) || (op == dmc_pkg::OP_RD_PROG) ||
               (op == dmc_pkg::OP_WR_DATA) || (op == dmc_pkg::OP_RD_DATA);
  endfunction

  // access refused: program memory needs debug and no protection, data memory reads need debug
  function automatic logic refused(input logic [7:0] op, input logic in_debug, input logic prot);
    refused = !in_debug || (prot && (op != dmc_pkg::OP_RD_DATA));
  endfunction

  wire logic is_prog = (op_q == dmc_pkg::OP_WR_PROG) || (op_q == dmc_pkg::OP_RD_PROG);
  wire logic is_rd   = (op_q == dmc_pkg::OP_RD_PROG) || (op_q == dmc_pkg::OP_RD_DATA);
  wire logic tx_free = !tx_valid || tx_ready;

  // frame sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= dmc_pkg::ST_OPCODE;
      op_q    <= 8'h00;
      addr_q  <= 16'h0000;
      left_q  <= 17'h00000;
      blank_q <= 1'b0;
    end else begin
      case (state_q)
        dmc_pkg::ST_OPCODE: begin
          if (rx_valid && is_known(rx_data)) begin
            op_q    <= rx_data;
            state_q <= dmc_pkg::ST_ADDR_HI;
          end
        end
        dmc_pkg::ST_ADDR_HI: begin
          if (rx_valid) begin
            addr_q[15:8] <= rx_data;
            state_q      <= dmc_pkg::ST_ADDR_LO;
          end
        end
        dmc_pkg::ST_ADDR_LO: begin
          if (rx_valid) begin
            addr_q[7:0] <= rx_data;
            state_q     <= dmc_pkg::ST_CNT_HI;
          end
        end
        dmc_pkg::ST_CNT_HI: begin
          if (rx_valid) begin
            left_q[15:8] <= rx_data;
            state_q      <= dmc_pkg::ST_CNT_LO;
          end
        end
        dmc_pkg::ST_CNT_LO: begin
          if (rx_valid) begin
            left_q[7:0] <= rx_data;
            left_q[16]  <= (left_q[15:8] == 8'h00) && (rx_data == 8'h00);
            blank_q     <= refused(op_q, debug_mode, read_protect);
            state_q     <= is_rd ? dmc_pkg::ST_READ : dmc_pkg::ST_WRITE;
          end
        end
        dmc_pkg::ST_WRITE: begin
          if (rx_valid) begin
            addr_q <= addr_q + 16'h0001;
            left_q <= left_q - 17'h00001;
            if (left_q == 17'h00001)
              state_q <= dmc_pkg::ST_OPCODE;
          end
        end
        dmc_pkg::ST_READ: begin
          if (tx_free) begin
            state_q <= blank_q ? dmc_pkg::ST_READ : dmc_pkg::ST_READ_WAIT;
            if (blank_q) begin
              addr_q <= addr_q + 16'h0001;
              left_q <= left_q - 17'h00001;
              if (left_q == 17'h00001)
                state_q <= dmc_pkg::ST_OPCODE;
            end
          end
        end
        dmc_pkg::ST_READ_WAIT: begin
          if (mem_rd_valid) begin
            addr_q  <= addr_q + 16'h0001;
            left_q  <= left_q - 17'h00001;
            state_q <= (left_q == 17'h00001) ? dmc_pkg::ST_OPCODE : dmc_pkg::ST_READ;
          end
        end
        default: state_q <= dmc_pkg::ST_OPCODE;
      endcase
    end
  end

  // memory requests; writes under refusal are consumed but not issued
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_req <= '0;
    end else begin
      mem_req.valid <= 1'b0;
      mem_req.prog  <= is_prog;
      mem_req.addr  <= addr_q;
      mem_req.wr    <= 1'b0;
      if (state_q == dmc_pkg::ST_WRITE && rx_valid && !blank_q) begin
        mem_req.valid <= 1'b1;
        mem_req.wr    <= 1'b1;
        mem_req.wdata <= rx_data;
      end else if (state_q == dmc_pkg::ST_READ && tx_free && !blank_q) begin
        mem_req.valid <= 1'b1;
      end
    end
  end

  // returned bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (state_q == dmc_pkg::ST_READ && tx_free && blank_q) begin
      tx_valid <= 1'b1;
      tx_data  <= dmc_pkg::BLANK_BYTE;
    end else if (state_q == dmc_pkg::ST_READ_WAIT && mem_rd_valid) begin
      tx_valid <= 1'b1;
      tx_data  <= mem_rd_data;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst)
      busy <= 1'b0;
    else
      busy <= (state_q != dmc_pkg::ST_OPCODE);
  end

  chk_count_zero_full: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_CNT_LO && rx_valid && left_q[15:8] == 8'h00 && rx_data == 8'h00)
      |=> (left_q == 17'h10000))
    else $error("zero count not taken as 65536");

  chk_write_refused: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_WRITE && blank_q) |=> !(mem_req.valid && mem_req.wr))
    else $error("write issued while refused");

  chk_prog_read_blank: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_READ && tx_free && blank_q && is_prog)
      |=> (tx_valid && tx_data == 8'hFF))
    else $error("refused program read did not return FFH");

  chk_data_read_prot: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_CNT_LO && rx_valid && op_q == dmc_pkg::OP_RD_DATA && debug_mode)
      |=> !blank_q)
    else $error("data read blanked in debug mode");

  chk_data_write_prot: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_CNT_LO && rx_valid && op_q == dmc_pkg::OP_WR_DATA && read_protect)
      |=> blank_q)
    else $error("protected data write not refused");

  chk_addr_step: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_WRITE && rx_valid) |=> (addr_q == $past(addr_q) + 16'h0001))
    else $error("address did not advance");

  sequence s_read_issue;
    state_q == dmc_pkg::ST_READ && tx_free && !blank_q;
  endsequence
  chk_read_request: assert property (@(posedge clk) disable iff (srst)
    s_read_issue |=> (mem_req.valid && !mem_req.wr && mem_req.addr == $past(addr_q)))
    else $error("read request missing");

  chk_read_return: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_READ_WAIT && mem_rd_valid) |=> (tx_valid && tx_data == $past(mem_rd_data)))
    else $error("read byte not returned");

  chk_data_read_blank: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_READ && tx_free && blank_q && !is_prog)
      |=> (tx_valid && tx_data == dmc_pkg::BLANK_BYTE))
    else $error("refused data read did not return FFH");

  chk_prog_refuse: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_CNT_LO && rx_valid && is_prog && (!debug_mode || read_protect))
      |=> blank_q)
    else $error("program access not refused");

  chk_blank_no_fetch: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_READ && blank_q) |=> !mem_req.valid)
    else $error("memory read issued while refused");

  chk_read_addr_step: assert property (@(posedge clk) disable iff (srst)
    (state_q == dmc_pkg::ST_READ_WAIT && mem_rd_valid)
      |=> (addr_q == $past(addr_q) + 16'h0001))
    else $error("read address did not advance");

  chk_tx_hold: assert property (@(posedge clk) disable iff (srst)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data)))
    else $error("returned byte dropped before it was taken");

  // the last fetched byte of a frame returns the interpreter to opcode hunting
  sequence s_last_fetch;
    state_q == dmc_pkg::ST_READ_WAIT && mem_rd_valid && left_q == 17'h00001;
  endsequence
  chk_read_frame_end: assert property (@(posedge clk) disable iff (srst)
    s_last_fetch |=> (state_q == dmc_pkg::ST_OPCODE))
    else $error("read frame did not end after its count");
endmodule // dmc_mem_cmd
`default_nettype wire

// ==== dmc_mem_model.sv ====
/*
 behavioural program and data memory behind dmc_mem_cmd, read latency two cycles.
 assumes mem_req pulses for one cycle; contents start as the low address byte.
*/
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model (
  input  wire logic           clk,
  input  wire dmc_pkg::dmc_mem_req_s mem_req,
  output logic                mem_rd_valid,
  output logic [7:0]          mem_rd_data
);
  logic [7:0] m [2][512];
  logic [7:0] q;
  logic       p1;
  initial begin
    for (int i = 0; i < 512; i++) begin
      m[0][i] = 8'(i);
      m[1][i] = 8'(i);
    end
    p1 = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rd_data = 8'h00;
  end
  always @(posedge clk) begin
    p1 <= mem_req.valid && !mem_req.wr;
    q <= m[mem_req.prog][mem_req.addr[8:0]];
    if (mem_req.valid && mem_req.wr) m[mem_req.prog][mem_req.addr[8:0]] <= mem_req.wdata;
    mem_rd_valid <= p1;
    // outside a pulse the data bus shows a changing pattern
    mem_rd_data <= p1 ? q : ~mem_rd_data;
  end
endmodule // dmc_mem_model
`default_nettype wire

// ==== testbench.sv ====
/*
 self-checking bench for dmc_mem_cmd acting as the debug host.
 assumes dmc_mem_model as memory and dmc_pkg compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, srst, debug_mode, read_protect, rx_valid, tx_ready, tx_valid, mem_rd_valid, busy;
  logic [7:0] rx_data, tx_data, mem_rd_data;
  dmc_pkg::dmc_mem_req_s mem_req;
  int fails, cmp_count;
  dmc_mem_cmd dut (.clk(clk), .srst(srst), .debug_mode(debug_mode),
    .read_protect(read_protect), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .mem_req(mem_req),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .busy(busy));
  dmc_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic frm(logic [7:0] op, logic [15:0] a, logic [15:0] c, int n, logic [7:0] d0);
    logic [7:0] h [5];
    h = '{op, a[15:8], a[7:0], c[15:8], c[7:0]};
    for (int i = 0; i < 5 + n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= (i < 5) ? h[i] : d0 + 8'(i - 5);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
  // host stalls one cycle before taking each returned byte
  task automatic rd(logic [7:0] op, logic [15:0] a, int n, logic [7:0] e0, logic [7:0] inc);
    int t;
    frm(op, a, 16'(n), 0, 8'h00);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      tx_ready <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (tx_valid !== 1'b1 && t < 50);
      tx_ready <= 1'b0;
      chk("tx_valid", 8'h01, {7'h00, tx_valid});
      chk("tx_data", e0 + 8'(k) * inc, tx_data);
    end
  endtask
  task automatic s_prog();
    debug_mode <= 1'b1;
    frm(dmc_pkg::OP_WR_PROG, 16'h00FF, 16'h0002, 2, 8'h30);
    rd(dmc_pkg::OP_RD_PROG, 16'h00FF, 2, 8'h30, 8'h01);
  endtask
  task automatic s_prot();
    read_protect <= 1'b1;
    frm(dmc_pkg::OP_WR_PROG, 16'h00FF, 16'h0002, 2, 8'h50);
    rd(dmc_pkg::OP_RD_PROG, 16'h00FF, 2, 8'hFF, 8'h00);
    frm(dmc_pkg::OP_WR_DATA, 16'h0010, 16'h0001, 1, 8'h77);
    rd(dmc_pkg::OP_RD_DATA, 16'h0010, 1, 8'h10, 8'h00);
    read_protect <= 1'b0;
    rd(dmc_pkg::OP_RD_PROG, 16'h00FF, 2, 8'h30, 8'h01);
  endtask
  task automatic s_data();
    frm(dmc_pkg::OP_WR_DATA, 16'h0010, 16'h0003, 3, 8'h40);
    rd(dmc_pkg::OP_RD_DATA, 16'h0010, 3, 8'h40, 8'h01);
    debug_mode <= 1'b0;
    rd(dmc_pkg::OP_RD_DATA, 16'h0010, 1, 8'hFF, 8'h00);
    rd(dmc_pkg::OP_RD_PROG, 16'h0000, 1, 8'hFF, 8'h00);
  endtask
  // refused write of count 0 must swallow exactly 65536 data bytes
  task automatic s_cnt0();
    frm(dmc_pkg::OP_WR_PROG, 16'h00FF, 16'h0000, 65535, 8'h00);
    repeat (2) @(posedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    debug_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    rd(dmc_pkg::OP_RD_PROG, 16'h00FF, 1, 8'h30, 8'h00);
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    debug_mode = 1'b0;
    read_protect = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("busy", 8'h00, {7'h00, busy});
    s_prog();
    s_prot();
    s_data();
    s_cnt0();
    close_out();
  end
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
